// file: ltcp_map.svh
// Constants of the loop transmit cell poll and enable handshake block.
// Assumes inclusion by the package and the design files by bare name.
`ifndef LTCP_MAP_SVH
`define LTCP_MAP_SVH

// ==========================================================================
// Register offsets on the APB byte address
// ==========================================================================
`define LTCP_OFS_CTRL 12'h000
`define LTCP_OFS_SADDR 12'h004
`define LTCP_OFS_PLAST 12'h008
`define LTCP_OFS_STATUS 12'h00C

// ==========================================================================
// Control register fields and reset values
// ==========================================================================
`define LTCP_CTRL_EN 0
`define LTCP_CTRL_MASTER 1
`define LTCP_CTRL_PREPEND 2
`define LTCP_CTRL_TWO 3
`define LTCP_CTRL_W 4
`define LTCP_CTRL_RST 4'h0
`define LTCP_SADDR_W 6
`define LTCP_SADDR_RST 6'h00
`define LTCP_PLAST_RST 12'h7FF

// ==========================================================================
// Poll timing and credit values
// ==========================================================================
`define LTCP_N_UTOPIA 1
`define LTCP_N_PREPEND 2
`define LTCP_NULL_ADDR 12'hFFF
`define LTCP_CREDIT_ONE 2'h1
`define LTCP_CREDIT_TWO 2'h2
`define LTCP_CREDIT_NONE 2'h0

`endif

// file: ltcp_pkg.sv
// Types shared by the loop transmit poll handshake block.
// Assumes ltcp_map.svh is on the include path.
package ltcp_pkg;
	`include "ltcp_map.svh"

	typedef enum logic [2:0] {
		LTCP_M_IDLE = 3'b001,
		LTCP_M_SEL = 3'b010,
		LTCP_M_XFER = 3'b100
	} ltcp_mst_t;
endpackage : ltcp_pkg

// file: ltcp_poll_seq.sv
// Poll address sequencer for master mode.
// Assumes the caller registers its output onto the address pins.
`timescale 1ns/1ns
module ltcp_poll_seq
	import ltcp_pkg::*;
#(
	parameter int AW = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic run,
	input wire logic hold,
	input wire logic [AW-1:0] last_chan,
	output logic [AW-1:0] poll_addr,
	output logic poll_vld
);
	typedef struct packed {
		logic phase;
		logic [AW-1:0] chan;
		logic [AW-1:0] addr;
		logic vld;
	} ltcp_seq_t;

	ltcp_seq_t seq_reg;
	ltcp_seq_t seq_next;

	// ======================================================================
	// Address then null, advancing one channel per pair
	// ======================================================================
	always_comb
	begin
		seq_next = seq_reg;
		seq_next.vld = 1'b0;
		if (!run)
		begin
			seq_next.phase = 1'b0;
			seq_next.chan = '0;
		end
		else if (hold)
		begin
			// The presented poll is dropped, so the same channel comes again.
			seq_next.phase = 1'b0;
		end
		else if (!seq_reg.phase)
		begin
			seq_next.addr = seq_reg.chan;
			seq_next.vld = 1'b1;
			seq_next.phase = 1'b1;
		end
		else
		begin
			seq_next.phase = 1'b0;
			if (seq_reg.chan >= last_chan)
				seq_next.chan = '0;
			else
				seq_next.chan = seq_reg.chan + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_reg <= '0;
		else if (ce)
			seq_reg <= seq_next;
	end

	assign poll_addr = seq_reg.addr;
	assign poll_vld = seq_reg.vld;
endmodule : ltcp_poll_seq

// file: ltcp_top.sv
// Loop transmit cell poll and transmit enable handshake, master and slave.
// Assumes the loop transmit clock is pclk and pins settle on its edges.
// Operation
// - Interface disabled: space-available and enable pins are high impedance.
// - Master samples space-available N clocks after presenting the address.
// - Asserted space-available means room for K cells, K from two-cell bit.
// - Slave drives space-available one clock after low address bits match.
// - Slave drives space-available high only with a cell ready, else low.
// - All pin sampling, updates and release happen on the rising edge.
// - Transfer target is the address shown while enable was last high.
// - Master drives enable and keeps it low for the whole cell transfer.
// - Master presents polls N clocks ahead and inserts null addresses.
`timescale 1ns/1ns
`include "ltcp_map.svh"
module ltcp_top
	import ltcp_pkg::*;
#(
	parameter int AW = 12,
	parameter int NCH = 2048
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_cell_space_avail_i,
	output logic tx_cell_space_avail_o,
	output logic tx_cell_space_avail_oe,
	input wire logic tx_xfer_enable_n_i,
	output logic tx_xfer_enable_n_o,
	output logic tx_xfer_enable_n_oe,
	input wire logic [AW-1:0] tx_poll_chan_addr_i,
	output logic [AW-1:0] tx_poll_chan_addr_o,
	output logic tx_poll_chan_addr_oe,
	input wire logic xfer_req,
	input wire logic [AW-1:0] xfer_chan,
	input wire logic xfer_done,
	input wire logic cell_ready,
	output logic xfer_start,
	output logic xfer_busy,
	output logic slave_xfer_act
);
	typedef struct packed {
		logic [`LTCP_CTRL_W-1:0] ctrl;
		logic [`LTCP_SADDR_W-1:0] saddr;
		logic [AW-1:0] plast;
		logic [31:0] prdata;
		ltcp_mst_t st;
		logic [AW-1:0] tgt;
		logic [AW-1:0] addr_o;
		logic addr_oe;
		logic en_n_o;
		logic en_oe;
		logic pa_o;
		logic pa_oe;
		logic [2:0] pv;
		logic [3*AW-1:0] pc;
		logic [2*NCH-1:0] credit;
		logic s_sel;
		logic s_act;
		logic start;
	} ltcp_state_t;

	ltcp_state_t s_reg;
	ltcp_state_t s_next;
	logic [AW-1:0] poll_addr;
	logic poll_vld;
	logic sel_now;
	logic mst;
	logic slv;
	logic match;
	logic samp_vld;
	logic [AW-1:0] samp_chan;
	logic [1:0] k_val;

	// ======================================================================
	// Register decode
	// ======================================================================
	function automatic logic [2:0] ltcp_dec(input logic [11:0] a);
		if (a == `LTCP_OFS_CTRL)
			return {1'b1, 2'd0};
		else if (a == `LTCP_OFS_SADDR)
			return {1'b1, 2'd1};
		else if (a == `LTCP_OFS_PLAST)
			return {1'b1, 2'd2};
		else if (a == `LTCP_OFS_STATUS)
			return {1'b1, 2'd3};
		else
			return 3'h0;
	endfunction : ltcp_dec

	function automatic logic [1:0] ltcp_cr(input logic [2*NCH-1:0] c,
		input logic [AW-1:0] ch);
		return c[2*int'(ch) +: 2];
	endfunction : ltcp_cr

	assign mst = s_reg.ctrl[`LTCP_CTRL_EN] & s_reg.ctrl[`LTCP_CTRL_MASTER];
	assign slv = s_reg.ctrl[`LTCP_CTRL_EN] & ~s_reg.ctrl[`LTCP_CTRL_MASTER];
	assign match = tx_poll_chan_addr_i[`LTCP_SADDR_W-1:0] == s_reg.saddr;
	assign k_val = s_reg.ctrl[`LTCP_CTRL_TWO] ? `LTCP_CREDIT_TWO :
		`LTCP_CREDIT_ONE;
	// The sampled poll sits N stages down the pending pipeline.
	assign samp_vld = s_reg.ctrl[`LTCP_CTRL_PREPEND] ?
		s_reg.pv[`LTCP_N_PREPEND] : s_reg.pv[`LTCP_N_UTOPIA];
	assign samp_chan = s_reg.ctrl[`LTCP_CTRL_PREPEND] ?
		s_reg.pc[`LTCP_N_PREPEND*AW +: AW] :
		s_reg.pc[`LTCP_N_UTOPIA*AW +: AW];
	assign sel_now = (s_reg.st == LTCP_M_IDLE) && mst && xfer_req &&
		(ltcp_cr(s_reg.credit, xfer_chan) != `LTCP_CREDIT_NONE);

	ltcp_poll_seq #(
		.AW(AW)
	) u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(mst),
		.hold(sel_now),
		.last_chan(s_reg.plast),
		.poll_addr(poll_addr),
		.poll_vld(poll_vld)
	);

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb
	begin
		logic [2:0] d;
		d = ltcp_dec(paddr);
		s_next = s_reg;
		s_next.start = 1'b0;
		if (psel && !penable)
		begin
			if (d[1:0] == 2'd0)
				s_next.prdata = 32'({s_reg.ctrl});
			else if (d[1:0] == 2'd1)
				s_next.prdata = 32'({s_reg.saddr});
			else if (d[1:0] == 2'd2)
				s_next.prdata = 32'({s_reg.plast});
			else
				s_next.prdata = 32'({s_reg.s_act, s_reg.s_sel,
					s_reg.st, s_reg.tgt});
			if (!d[2])
				s_next.prdata = 32'h0;
		end
		if (psel && penable && pwrite && d[2])
		begin
			if (d[1:0] == 2'd0)
				s_next.ctrl = pwdata[`LTCP_CTRL_W-1:0];
			else if (d[1:0] == 2'd1)
				s_next.saddr = pwdata[`LTCP_SADDR_W-1:0];
			else if (d[1:0] == 2'd2)
				s_next.plast = pwdata[AW-1:0];
		end

		// Master transfer sequence.
		case (s_reg.st)
			LTCP_M_IDLE:
			begin
				s_next.en_n_o = 1'b1;
				if (sel_now)
				begin
					s_next.st = LTCP_M_SEL;
					s_next.tgt = xfer_chan;
					s_next.credit[2*int'(xfer_chan) +: 2] =
						ltcp_cr(s_reg.credit, xfer_chan) - 2'h1;
				end
			end
			LTCP_M_SEL:
			begin
				// Enable was high with the target shown; now it falls.
				s_next.st = mst ? LTCP_M_XFER : LTCP_M_IDLE;
				s_next.en_n_o = ~mst;
				s_next.start = mst;
			end
			LTCP_M_XFER:
			begin
				if (xfer_done || !mst)
				begin
					s_next.st = LTCP_M_IDLE;
					s_next.en_n_o = 1'b1;
				end
				else
					s_next.en_n_o = 1'b0;
			end
			default:
			begin
				s_next.st = LTCP_M_IDLE;
				s_next.en_n_o = 1'b1;
			end
		endcase

		// A fresh poll result wins over a credit taken in the same cycle.
		if (mst && samp_vld)
			s_next.credit[2*int'(samp_chan) +: 2] = tx_cell_space_avail_i ?
				k_val : `LTCP_CREDIT_NONE;
		if (!mst)
			s_next.credit = '0;

		if (sel_now)
			s_next.addr_o = xfer_chan;
		else if (poll_vld)
			s_next.addr_o = poll_addr;
		else
			s_next.addr_o = AW'(`LTCP_NULL_ADDR);
		s_next.pv = {s_reg.pv[1:0], poll_vld & ~sel_now & mst};
		s_next.pc = {s_reg.pc[2*AW-1:0], poll_addr};
		s_next.addr_oe = mst;
		s_next.en_oe = mst;

		// Slave answer and selection.
		s_next.pa_oe = slv & match;
		s_next.pa_o = slv & match & cell_ready;
		if (slv && tx_xfer_enable_n_i)
			s_next.s_sel = match;
		s_next.s_act = slv & ~tx_xfer_enable_n_i & s_reg.s_sel;
	end

	// ======================================================================
	// State register, rising edge only
	// ======================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.ctrl <= `LTCP_CTRL_RST;
			s_reg.saddr <= `LTCP_SADDR_RST;
			s_reg.plast <= AW'(`LTCP_PLAST_RST);
			s_reg.st <= LTCP_M_IDLE;
			s_reg.en_n_o <= 1'b1;
		end
		else if (ce)
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (ltcp_dec(paddr) == 3'h0);
	assign tx_cell_space_avail_o = s_reg.pa_o;
	assign tx_cell_space_avail_oe = s_reg.pa_oe;
	assign tx_xfer_enable_n_o = s_reg.en_n_o;
	assign tx_xfer_enable_n_oe = s_reg.en_oe;
	assign tx_poll_chan_addr_o = s_reg.addr_o;
	assign tx_poll_chan_addr_oe = s_reg.addr_oe;
	assign xfer_start = s_reg.start;
	assign xfer_busy = s_reg.st == LTCP_M_XFER;
	assign slave_xfer_act = s_reg.s_act;

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_off_hiz;
		ce && !s_reg.ctrl[`LTCP_CTRL_EN] |=> !tx_cell_space_avail_oe &&
			!tx_xfer_enable_n_oe;
	endproperty
	a_off_hiz: assert property (p_off_hiz)
		else $error("pins driven while interface disabled");

	property p_poll_sample;
		ce && mst && samp_vld && s_next.ctrl[`LTCP_CTRL_EN] &&
			s_next.ctrl[`LTCP_CTRL_MASTER] |=>
			ltcp_cr(s_reg.credit, $past(samp_chan)) ==
			($past(tx_cell_space_avail_i) ? $past(k_val) : 2'h0);
	endproperty
	a_poll_sample: assert property (p_poll_sample)
		else $error("poll result not recorded at sample offset");

	property p_two_cell;
		ce && mst && samp_vld && tx_cell_space_avail_i &&
			s_reg.ctrl[`LTCP_CTRL_TWO] && s_next.ctrl == s_reg.ctrl |=>
			ltcp_cr(s_reg.credit, $past(samp_chan)) == 2'h2;
	endproperty
	a_two_cell: assert property (p_two_cell)
		else $error("two cell credit not granted");

	property p_slave_drive;
		ce && slv && match |=> tx_cell_space_avail_oe;
	endproperty
	a_slave_drive: assert property (p_slave_drive)
		else $error("slave did not answer its poll");

	property p_slave_level;
		ce && slv && match |=> tx_cell_space_avail_o == $past(cell_ready);
	endproperty
	a_slave_level: assert property (p_slave_level)
		else $error("slave answer does not match cell readiness");

	property p_no_stray;
		ce && !(slv && match) |=> !tx_cell_space_avail_oe;
	endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("space pin driven without a match");

	property p_target;
		$fell(tx_xfer_enable_n_o) |-> $past(tx_poll_chan_addr_o) == s_reg.tgt;
	endproperty
	a_target: assert property (p_target)
		else $error("target not on address while enable high");

	property p_hold_low;
		ce && xfer_busy && !xfer_done && mst |=> !tx_xfer_enable_n_o;
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("enable rose during a transfer");

	property p_null;
		ce && mst && s_reg.pv[0] |=> tx_poll_chan_addr_o == `LTCP_NULL_ADDR ||
			s_reg.st == LTCP_M_SEL;
	endproperty
	a_null: assert property (p_null)
		else $error("no null cycle after a poll address");

	property p_credit;
		$rose(s_reg.st == LTCP_M_SEL) |-> $past(ltcp_cr(s_reg.credit,
			xfer_chan)) != 2'h0;
	endproperty
	a_credit: assert property (p_credit)
		else $error("transfer started without poll credit");
endmodule : ltcp_top

// file: ltcp_phy_model.sv
// Far-side model: physical layer devices answering master polls.
// Assumes the device drives poll addresses on rising edges of pclk.
`timescale 1ns/1ns
module ltcp_phy_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic prepend,
	input wire logic [3:0] avail,
	input wire logic [11:0] addr,
	input wire logic addr_oe,
	output logic pa,
	output logic pa_oe
);
	logic [11:0] addr_d;
	logic [11:0] sel;
	logic hit;
	// ==========================================================
	// Poll answer
	// Channels 0 to 3 live here; a released pin shows the inverse level.
	assign sel = prepend ? addr_d : addr;
	assign hit = addr_oe && (sel < 12'h004);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_d <= 12'hFFF;
			pa <= 1'b0;
			pa_oe <= 1'b0;
		end
		else
		begin
			addr_d <= addr_oe ? addr : 12'hFFF;
			pa_oe <= hit;
			// A set bit means room for K whole cells on that channel.
			pa <= hit ? avail[sel[1:0]] : ~pa;
		end
	end
endmodule : ltcp_phy_model

// file: testbench.sv
// Self-checking bench of the loop transmit poll and enable handshake.
// Assumes ltcp_pkg and ltcp_map.svh are compiled and on the include path.
`timescale 1ns/1ns
`include "ltcp_map.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, tb_addr, xfer_chan, ad_o, ad_w;
	logic [31:0] pwdata, prdata, r;
	logic sp_o, sp_oe, en_o, en_oe, ad_oe, ph_pa, sp_w, en_w, tb_en_n;
	logic xfer_req, xfer_done, cell_ready, xfer_start, xfer_busy, act;
	logic prepend, e, ce;
	logic [3:0] avail;
	int miscompares = 0;
	int cmp_count = 0;
	assign ad_w = ad_oe ? ad_o : tb_addr;
	assign en_w = en_oe ? en_o : tb_en_n;
	assign sp_w = sp_oe ? sp_o : ph_pa;
	ltcp_top u_ltcp_top (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_cell_space_avail_i(sp_w),
		.tx_cell_space_avail_o(sp_o), .tx_cell_space_avail_oe(sp_oe),
		.tx_xfer_enable_n_i(en_w), .tx_xfer_enable_n_o(en_o),
		.tx_xfer_enable_n_oe(en_oe), .tx_poll_chan_addr_i(ad_w),
		.tx_poll_chan_addr_o(ad_o), .tx_poll_chan_addr_oe(ad_oe),
		.xfer_req(xfer_req), .xfer_chan(xfer_chan), .xfer_done(xfer_done),
		.cell_ready(cell_ready), .xfer_start(xfer_start),
		.xfer_busy(xfer_busy), .slave_xfer_act(act));
	ltcp_phy_model u_ltcp_phy_model (.pclk(pclk), .presetn(presetn),
		.prepend(prepend), .avail(avail), .addr(ad_w), .addr_oe(ad_oe),
		.pa(ph_pa), .pa_oe());
	// ==========================================================
	// Shared tasks
	task complete_run;
	begin
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	end
	endtask : chk
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask : apb
	// ==========================================================
	// Scenarios
	task t_regs;
	begin
		chk({sp_oe, en_oe, ad_oe}, 0, "pins driven at reset");
		apb(`LTCP_OFS_CTRL, 1'b0, 0);
		chk(r, 0, "control reset");
		apb(`LTCP_OFS_PLAST, 1'b0, 0);
		chk(r, 32'h000007FF, "last channel reset");
		apb(12'h010, 1'b0, 0);
		chk(r, 0, "unmapped read data");
		chk(e, 1, "unmapped read error");
	end
	endtask : t_regs
	task t_master(input logic pre, input logic [31:0] ctl);
		int n;
		logic f;
		logic [11:0] pa;
		logic pe;
	begin
		prepend <= pre;
		avail <= 4'h4;
		apb(`LTCP_OFS_PLAST, 1'b1, 3);
		apb(`LTCP_OFS_CTRL, 1'b1, ctl);
		repeat (3) @(posedge pclk);
		#1;
		chk(sp_oe, 0, "space pin driven in master");
		@(posedge pclk);
		ce <= 1'b0;
		#1;
		pa = ad_o;
		repeat (3) @(posedge pclk);
		#1;
		chk(ad_o, pa, "address moved while clock enable low");
		@(posedge pclk);
		ce <= 1'b1;
		#1;
		f = (ad_o === 12'hFFF);
		for (n = 0; n < 8; n++)
		begin
			@(posedge pclk);
			#1;
			chk(ad_o === 12'hFFF, !f, "null cycle");
			f = !f;
		end
		@(posedge pclk);
		xfer_chan <= 12'h001;
		xfer_req <= 1'b1;
		n = 0;
		repeat (20)
		begin
			@(posedge pclk);
			#1;
			n += (xfer_start === 1'b1);
		end
		chk(n, 0, "start without credit");
		@(posedge pclk);
		xfer_chan <= 12'h002;
		n = 0;
		#1;
		while (xfer_start !== 1'b1 && n < 40)
		begin
			pa = ad_o;
			pe = en_o;
			@(posedge pclk);
			#1;
			n++;
		end
		chk(xfer_start, 1, "no transfer start");
		chk({pe, pa}, 13'h1002, "target before enable");
		@(posedge pclk);
		xfer_req <= 1'b0;
		repeat (4)
		begin
			#1;
			chk({en_oe, en_o, xfer_busy}, 3'b101, "enable low");
			@(posedge pclk);
		end
		xfer_done <= 1'b1;
		@(posedge pclk);
		xfer_done <= 1'b0;
		#1;
		chk({en_o, xfer_busy}, 2'b10, "enable after end");
		apb(`LTCP_OFS_STATUS, 1'b0, 0);
		chk(r, 32'h00001002, "status after transfer");
	end
	endtask : t_master
	task slv(input logic [11:0] a, input logic exp);
		int n;
	begin
		@(posedge pclk);
		tb_en_n <= 1'b1;
		tb_addr <= a;
		repeat (2) @(posedge pclk);
		tb_addr <= 12'h006;
		tb_en_n <= 1'b0;
		n = 0;
		repeat (4)
		begin
			@(posedge pclk);
			#1;
			n += (act === 1'b1);
		end
		chk(n > 0, exp, "slave transfer select");
	end
	endtask : slv
	task t_slave;
		int i;
	begin
		apb(`LTCP_OFS_SADDR, 1'b1, 5);
		apb(`LTCP_OFS_CTRL, 1'b1, 1);
		for (i = 0; i < 3; i++)
		begin
			@(posedge pclk);
			tb_addr <= (i == 2) ? 12'h006 : 12'h045;
			cell_ready <= (i == 0);
			@(posedge pclk);
			#1;
			chk({sp_oe, sp_oe & sp_o}, (i == 2) ? 0 : {1'b1, i == 0},
				"slave answer");
			chk(en_oe, 0, "enable driven in slave");
		end
		slv(12'h006, 1'b0);
		slv(12'h045, 1'b1);
		apb(`LTCP_OFS_CTRL, 1'b1, 0);
		@(posedge pclk);
		#1;
		chk({sp_oe, en_oe, ad_oe}, 0, "pins driven when off");
	end
	endtask : t_slave
	// ==========================================================
	// Run
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial
	begin
		#500000;
		miscompares++;
		complete_run;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, xfer_req, xfer_done} = 0;
		{cell_ready, prepend, paddr, pwdata, xfer_chan} = 0;
		tb_addr = 12'h000;
		tb_en_n = 1'b1;
		ce = 1'b1;
		avail = 4'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_master(1'b0, 32'h3);
		t_master(1'b1, 32'hF);
		t_slave;
		complete_run;
	end
endmodule : testbench
